// File: hdl/sfqc_pkg.sv
/*
 Constants, types and helpers for the serial flash read-configuration command block.
 Assumes one link-side clock (the serial clock) and one system clock; nothing else.
*/
`default_nettype none

package sfqc_pkg;

	// Command codes
	localparam logic [7:0] OPC_UID        = 8'h4b;
	localparam logic [7:0] OPC_SET_PARM   = 8'hc0;
	localparam logic [7:0] OPC_FAST_READ  = 8'h0b;
	localparam logic [7:0] OPC_QUAD_IO    = 8'heb;
	localparam logic [7:0] OPC_BURST_WRAP = 8'h0c;
	localparam logic [7:0] OPC_SET_WRAP   = 8'h77;
	localparam logic [7:0] OPC_ENTER_4W   = 8'h38;
	localparam logic [7:0] OPC_EXIT_4W    = 8'hff;
	localparam logic [7:0] OPC_RST_EN     = 8'h66;
	localparam logic [7:0] OPC_RST        = 8'h99;

	// Serial clocks per phase, loaded as the count minus one
	localparam logic [5:0] CLK_OPC_SPI  = 6'h07;
	localparam logic [5:0] CLK_OPC_4W   = 6'h01;
	localparam logic [5:0] CLK_ADDR_SPI = 6'h17;
	localparam logic [5:0] CLK_ADDR_4W  = 6'h05;
	localparam logic [5:0] CLK_PARM_4W  = 6'h01;
	localparam logic [5:0] CLK_WRAP_SPI = 6'h07;
	localparam logic [5:0] CLK_UID_SPI  = 6'h1f;
	localparam logic [5:0] CLK_UID_4W   = 6'h07;
	localparam logic [5:0] CLK_BYTE_SPI = 6'h07;
	localparam logic [5:0] CLK_BYTE_4W  = 6'h01;

	// Field positions
	localparam int QPI_DUMMY_HI = 5;
	localparam int QPI_DUMMY_LO = 4;
	localparam int QPI_WRAP_HI  = 1;
	localparam int QPI_WRAP_LO  = 0;
	localparam int SPI_WRAP_HI  = 6;
	localparam int SPI_WRAP_LO  = 5;

	// Reset values: wrap of 8 bytes, 2 four-wire dummy clocks, 8 SPI dummy clocks
	localparam logic [1:0] DEF_DUMMY_CODE = 2'h0;
	localparam logic [1:0] DEF_WRAP_CODE  = 2'h0;
	localparam logic [5:0] SPI_DUMMY_DEF  = 6'h08;
	localparam logic [5:0] WRAP_BASE      = 6'h08;

	localparam logic [3:0] OE_QUAD = 4'hf;
	localparam logic [3:0] OE_SPI  = 4'h2;
	localparam logic [3:0] OE_NONE = 4'h0;

	typedef enum logic [2:0] {
		ST_OPC,
		ST_ADDR,
		ST_PARM,
		ST_DUMMY,
		ST_DATA,
		ST_IGNORE
	} sfqc_state_e;

	typedef struct packed {
		logic       four_wire_command_mode;
		logic [1:0] qpi_dummy_field;
		logic [1:0] qpi_wrap_field;
	} sfqc_cfg_s;

	// Dummy clocks for the four-wire reads: 2, 4, 6 or 8
	function automatic logic [5:0] sfqc_dummy_clocks(input logic [1:0] code);
		sfqc_dummy_clocks = 6'({code, 1'b0}) + 6'h02;
	endfunction

	// Next byte address, optionally wrapping inside an aligned 8/16/32/64 byte window
	function automatic logic [23:0] sfqc_next_addr(input logic [23:0] a, input logic wrap, input logic [1:0] code);
		logic [23:0] mask;
		logic [23:0] inc;
		mask = (24'(WRAP_BASE) << code) - 24'h000001;
		inc  = a + 24'h000001;
		sfqc_next_addr = wrap ? ((a & ~mask) | (inc & mask)) : inc;
	endfunction

endpackage

`default_nettype wire

// File: hdl/sfqc_top.sv
/*
 Device-side command interpreter of a serial NOR flash: unique id read, SPI / four-wire
 mode switching, four-wire read parameters, wrap setting and fast / burst reads.
 Assumes the host drives link_sclk only while cs_n is low, changes io on falling edges
 and samples on rising ones. The array is read combinationally in the link domain.
*/
`timescale 1ns/1ps
`default_nettype none

module sfqc_top #(
	// Arbitrary value; each part is given its own at build time
	parameter logic [63:0] UNIQUE_ID = 64'h5a5a_0001_c3c3_0002
) (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 link_sclk,
	input  wire logic                 cs_n,
	input  wire logic [3:0]           io_in,
	output logic      [3:0]           io_out,
	output logic      [3:0]           io_oe,
	input  wire logic                 quad_enable_bit,
	input  wire logic [3:0]           spi_dummy_select_bits,
	output logic      [23:0]          mem_addr,
	input  wire logic [7:0]           mem_rdata,
	output sfqc_pkg::sfqc_cfg_s       cfg_status
);
	import sfqc_pkg::*;

	// System clock side
	logic        link_rst_q;
	sfqc_cfg_s   cfg_meta_q;
	sfqc_cfg_s   cfg_sync_q;

	// Link side, persistent
	logic        qe_meta_q;
	logic        qe_q;
	logic [3:0]  sel_meta_q;
	logic [3:0]  sel_q;
	logic        four_wire_q;
	logic [1:0]  dummy_code_q;
	logic [1:0]  wrap_code_q;
	logic        reset_arm_q;

	// Link side, per frame
	sfqc_state_e state_q;
	sfqc_state_e state_d;
	logic [5:0]  cnt_q;
	logic [5:0]  cnt_d;
	logic [31:0] sh_q;
	logic [23:0] addr_q;
	logic [63:0] out_sh_q;
	logic        op_wrap_q;
	logic        op_uid_q;
	logic        op_77_q;
	logic [3:0]  io_out_q;
	logic [3:0]  io_oe_q;

	// a four-wire opcode ends two clocks into the SPI-length count, so no reload is needed
	localparam logic [5:0] OPC_4W_END = CLK_OPC_SPI - CLK_OPC_4W;

	wire         frame_rst = cs_n | link_rst_q;
	wire         last      = (state_q == ST_OPC && four_wire_q) ? (cnt_q == OPC_4W_END) : (cnt_q == 6'h00);
	wire  [31:0] quad_in   = {sh_q[27:0], io_in};
	wire  [31:0] sh_in     = four_wire_q ? quad_in : {sh_q[30:0], io_in[0]};
	wire  [7:0]  opc       = sh_in[7:0];

	wire         opc_done   = (state_q == ST_OPC) && last;
	wire         addr_done  = (state_q == ST_ADDR) && last;
	wire         parm_done  = (state_q == ST_PARM) && last;
	wire         dummy_done = (state_q == ST_DUMMY) && last;
	wire         byte_done  = (state_q == ST_DATA) && last;
	wire         load_byte  = dummy_done | (byte_done & ~op_uid_q);

	// each mode recognises only its own switching and parameter codes
	wire         is_enter  = (opc == OPC_ENTER_4W) && !four_wire_q;
	// entry needs the quad enable bit
	wire         enter_ok  = is_enter && qe_q;
	wire         is_exit   = (opc == OPC_EXIT_4W) && four_wire_q;
	// parameter set refused outside four-wire mode
	wire         is_parm   = (opc == OPC_SET_PARM) && four_wire_q;
	wire         is_wrap77 = (opc == OPC_SET_WRAP) && !four_wire_q;
	wire         is_fast   = (opc == OPC_FAST_READ);
	wire         is_quadio = (opc == OPC_QUAD_IO) && four_wire_q;
	wire         is_burst  = (opc == OPC_BURST_WRAP) && four_wire_q;
	wire         is_uid    = (opc == OPC_UID);
	wire         is_rst_en = (opc == OPC_RST_EN);
	wire         is_rst    = (opc == OPC_RST) && reset_arm_q;
	wire         is_read   = is_fast | is_quadio | is_burst;

	// SPI fast read latency from the select bits, zero meaning the default
	wire  [5:0]  spi_dummy = (sel_q == 4'h0) ? SPI_DUMMY_DEF : {2'b00, sel_q};
	// four-wire read latency from the parameter field
	wire  [5:0]  read_dummy = four_wire_q ? sfqc_dummy_clocks(dummy_code_q) : spi_dummy;
	wire  [5:0]  byte_clks  = four_wire_q ? CLK_BYTE_4W : CLK_BYTE_SPI;

	// Reset request for the link side; it is a constant-only asynchronous reset there
	always_ff @(posedge clk)
	begin
		link_rst_q <= ~rst_n;
	end

	// Settings are static between commands, so a plain two-stage copy is enough here
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cfg_meta_q <= '0;
			cfg_sync_q <= '0;
		end
		else
		begin
			cfg_meta_q <= '{four_wire_q, dummy_code_q, wrap_code_q};
			cfg_sync_q <= cfg_meta_q;
		end
	end

	assign cfg_status = cfg_sync_q;

	// The serial clock stops between frames, so these copies age; both inputs are quasi-static
	always_ff @(posedge link_sclk or posedge link_rst_q)
	begin
		if (link_rst_q)
		begin
			qe_meta_q  <= 1'b0;
			qe_q       <= 1'b0;
			sel_meta_q <= 4'h0;
			sel_q      <= 4'h0;
		end
		else
		begin
			qe_meta_q  <= quad_enable_bit;
			qe_q       <= qe_meta_q;
			sel_meta_q <= spi_dummy_select_bits;
			sel_q      <= sel_meta_q;
		end
	end

	// Mode and read settings; write latch and suspend state live elsewhere and are never touched
	always_ff @(posedge link_sclk or posedge link_rst_q)
	begin
		if (link_rst_q)
		begin
			four_wire_q  <= 1'b0;
			dummy_code_q <= DEF_DUMMY_CODE;
			wrap_code_q  <= DEF_WRAP_CODE;
			reset_arm_q  <= 1'b0;
		end
		else if (opc_done && is_rst)
		begin
			four_wire_q  <= 1'b0;
			dummy_code_q <= DEF_DUMMY_CODE;
			wrap_code_q  <= DEF_WRAP_CODE;
			reset_arm_q  <= 1'b0;
		end
		else
		begin
			if (opc_done)
			begin
				reset_arm_q <= is_rst_en;
			end
			// single mode bit, set only by entry
			if (opc_done && enter_ok)
			begin
				four_wire_q <= 1'b1;
			end
			if (opc_done && is_exit)
			begin
				four_wire_q <= 1'b0;
			end
			if (parm_done && op_77_q)
			begin
				wrap_code_q <= quad_in[SPI_WRAP_HI:SPI_WRAP_LO];
			end
			else if (parm_done)
			begin
				dummy_code_q <= quad_in[QPI_DUMMY_HI:QPI_DUMMY_LO];
				wrap_code_q  <= quad_in[QPI_WRAP_HI:QPI_WRAP_LO];
			end
		end
	end

	// Command sequencer
	always_comb
	begin
		state_d = state_q;
		cnt_d   = cnt_q - 6'h01;
		unique case (state_q)
			ST_OPC:
			begin
				if (last)
				begin
					if (is_read)
					begin
						state_d = ST_ADDR;
						cnt_d   = four_wire_q ? CLK_ADDR_4W : CLK_ADDR_SPI;
					end
					else if (is_uid)
					begin
						// four dummy bytes at the current lane width
						state_d = ST_DUMMY;
						cnt_d   = four_wire_q ? CLK_UID_4W : CLK_UID_SPI;
					end
					else if (is_parm)
					begin
						state_d = ST_PARM;
						cnt_d   = CLK_PARM_4W;
					end
					else if (is_wrap77)
					begin
						state_d = ST_PARM;
						cnt_d   = CLK_WRAP_SPI;
					end
					else
					begin
						state_d = ST_IGNORE;
						cnt_d   = 6'h00;
					end
				end
			end
			ST_ADDR:
			begin
				if (last)
				begin
					state_d = ST_DUMMY;
					cnt_d   = read_dummy - 6'h01;
				end
			end
			ST_PARM:
			begin
				if (last)
				begin
					state_d = ST_IGNORE;
					cnt_d   = 6'h00;
				end
			end
			ST_DUMMY:
			begin
				if (last)
				begin
					state_d = ST_DATA;
					cnt_d   = byte_clks;
				end
			end
			ST_DATA:
			begin
				if (last)
				begin
					cnt_d = byte_clks;
				end
			end
			ST_IGNORE:
			begin
				cnt_d = 6'h00;
			end
		endcase
	end

	always_ff @(posedge link_sclk or posedge frame_rst)
	begin
		if (frame_rst)
		begin
			state_q <= ST_OPC;
			cnt_q   <= CLK_OPC_SPI;
		end
		else
		begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	// Shift register and per-frame opcode flags
	always_ff @(posedge link_sclk or posedge frame_rst)
	begin
		if (frame_rst)
		begin
			sh_q      <= '0;
			op_wrap_q <= 1'b0;
			op_uid_q  <= 1'b0;
			op_77_q   <= 1'b0;
		end
		else
		begin
			sh_q <= (state_q == ST_PARM) ? quad_in : sh_in;
			if (opc_done)
			begin
				op_wrap_q <= is_burst;
				op_uid_q  <= is_uid;
				op_77_q   <= is_wrap77;
			end
		end
	end

	always_ff @(posedge link_sclk or posedge frame_rst)
	begin
		if (frame_rst)
		begin
			addr_q   <= '0;
			out_sh_q <= '0;
		end
		else
		begin
			if (addr_done)
			begin
				addr_q <= sh_in[23:0];
			end
			else if (load_byte && !op_uid_q)
			begin
				// burst read wraps inside the aligned window
				addr_q <= sfqc_next_addr(addr_q, op_wrap_q, wrap_code_q);
			end
			if (dummy_done && op_uid_q)
			begin
				// id comes only from the fixed parameter
				out_sh_q <= UNIQUE_ID;
			end
			else if (load_byte)
			begin
				out_sh_q <= {mem_rdata, 56'h0};
			end
			else if (state_q == ST_DATA)
			begin
				out_sh_q <= four_wire_q ? {out_sh_q[59:0], 4'h0} : {out_sh_q[62:0], 1'b0};
			end
		end
	end

	// Output lanes stay off until the data phase
	// data leaves on falling edges, msb first
	always_ff @(negedge link_sclk or posedge frame_rst)
	begin
		if (frame_rst)
		begin
			io_out_q <= 4'h0;
			io_oe_q  <= OE_NONE;
		end
		else
		begin
			io_out_q <= four_wire_q ? out_sh_q[63:60] : {2'b00, out_sh_q[63], 1'b0};
			if (state_q == ST_DATA)
			begin
				io_oe_q <= four_wire_q ? OE_QUAD : OE_SPI;
			end
			else
			begin
				io_oe_q <= OE_NONE;
			end
		end
	end

	assign io_out   = io_out_q;
	assign io_oe    = io_oe_q;
	assign mem_addr = addr_q;

endmodule

`default_nettype wire

// File: bench/sfqc_properties.sv
/*
 Port-level assertions for sfqc_top.
 Bound to every sfqc_top; sees only its ports, all sampled on clk.
*/
`timescale 1ns/1ps
`default_nettype none

module sfqc_props (
	input wire logic                clk,
	input wire logic                rst_n,
	input wire logic                cs_n,
	input wire logic [3:0]          io_oe,
	input wire logic                quad_enable_bit,
	input wire sfqc_pkg::sfqc_cfg_s cfg_status
);
	import sfqc_pkg::*;

	logic mode;
	assign mode = cfg_status.four_wire_command_mode;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_cfg_reset_clear: assert property ($rose(rst_n) |-> cfg_status == '0)
		else $error("cfg_status not cleared by reset");
	a_oe_off_idle: assert property (cs_n |-> io_oe == OE_NONE)
		else $error("io_oe on while deselected");
	a_oe_lane_width: assert property (io_oe != OE_NONE |-> io_oe == (mode ? OE_QUAD : OE_SPI))
		else $error("io_oe lanes do not match mode");
	a_oe_quiet_opcode: assert property ($fell(cs_n) |-> (io_oe == OE_NONE) [*8])
		else $error("io_oe on during opcode");
	a_wrap_kept_entry: assert property ($rose(mode) |-> $stable(cfg_status.qpi_wrap_field))
		else $error("wrap changed on entry");
	a_wrap_kept_exit: assert property ($fell(mode) |-> $stable(cfg_status.qpi_wrap_field))
		else $error("wrap changed on exit");
	a_entry_needs_qe: assert property ($rose(mode) |-> quad_enable_bit)
		else $error("mode entered without quad enable");
	a_cfg_in_frame: assert property ($changed(cfg_status) |-> !$past(cs_n, 3))
		else $error("settings changed outside a frame");

	cover property ($rose(mode));
	cover property ($fell(mode));
	cover property (io_oe == OE_QUAD);
endmodule

bind sfqc_top sfqc_props sfqc_props_inst (
	.clk(clk),
	.rst_n(rst_n),
	.cs_n(cs_n),
	.io_oe(io_oe),
	.quad_enable_bit(quad_enable_bit),
	.cfg_status(cfg_status)
);

`default_nettype wire

// File: bench/sfqc_host.sv
/*
 Behavioural host controller driving chip select, serial clock and data lines.
 Assumes the bench calls its tasks one at a time; 80 ns serial clock, idle low.
*/
`timescale 1ns/1ps
`default_nettype none

module sfqc_host (
	output var logic       cs_n,
	output var logic       link_sclk,
	output var logic [3:0] io_in,
	input wire logic [3:0] io_out
);
	initial
	begin
		cs_n = 1'b1;
		link_sclk = 1'b0;
		io_in = 4'h0;
	end

	task automatic open();
		#43 cs_n = 1'b0;
	endtask

	// Bits change while the clock is low, sampled at each rise
	task automatic xfer(input logic [63:0] v, input int n, input bit q, output logic [63:0] r);
		r = '0;
		for (int i = n - 1; i >= 0; i--)
		begin
			io_in = q ? v[4*i+:4] : {~io_in[3:1], v[i]};
			#40 link_sclk = 1'b1;
			r = q ? {r[59:0], io_out} : {r[62:0], io_out[1]};
			#40 link_sclk = 1'b0;
		end
	endtask

	// Released lines show the inverse so stale data cannot pass
	task automatic close();
		#40 cs_n = 1'b1;
		io_in = ~io_in;
		#40;
	endtask
endmodule

`default_nettype wire

// File: bench/sfqc_top_tb.sv
/*
 Self-checking bench for sfqc_top with a host model and a simple array.
 Assumes sfqc_host and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none

module sfqc_top_tb;
	import sfqc_pkg::*;

	// Arbitrary value
	localparam logic [63:0] ID = 64'h0123_4567_89ab_cdef;

	logic        clk, rst_n, cs_n, link_sclk, qe;
	logic [3:0]  io_in, io_out, io_oe, sel;
	logic [23:0] mem_addr;
	logic [7:0]  mem_rdata;
	sfqc_cfg_s   cfg;
	logic [63:0] r;
	int          num_errors, checked, cyc;

	assign mem_rdata = mem_addr[7:0] ^ 8'h3c;

	sfqc_top #(.UNIQUE_ID(ID)) sfqc_top_inst (
		.clk(clk), .rst_n(rst_n), .link_sclk(link_sclk), .cs_n(cs_n),
		.io_in(io_in), .io_out(io_out), .io_oe(io_oe), .quad_enable_bit(qe),
		.spi_dummy_select_bits(sel), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .cfg_status(cfg)
	);

	sfqc_host sfqc_host_inst (.cs_n(cs_n), .link_sclk(link_sclk), .io_in(io_in), .io_out(io_out));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Ceiling well above the few thousand cycles the frames need
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			num_errors++;
			final_report();
		end
	end

	task automatic final_report();
		if (num_errors == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		checked++;
		if (g !== e)
		begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			num_errors++;
		end
	endtask

	task automatic chkcfg(input logic m, input logic [1:0] d, input logic [1:0] w);
		chk("cfg_status", {m, d, w}, 64'(cfg));
	endtask

	task automatic tx(input logic [63:0] v, input int n, input bit q);
		sfqc_host_inst.xfer(v, n, q, r);
	endtask

	// Leaves time for settings to cross into the clk domain
	task automatic frame_end();
		sfqc_host_inst.close();
		repeat (6) @(posedge clk);
	endtask

	task automatic t_uid();
		sfqc_host_inst.open();
		tx(OPC_UID, 8, 0);
		tx(0, 32, 0);
		tx(0, 64, 0);
		frame_end();
		chk("unique_id", ID, r);
	endtask

	task automatic t_refuse();
		sfqc_host_inst.open();
		tx(OPC_SET_PARM, 8, 0);
		tx(8'h33, 8, 0);
		frame_end();
		chkcfg(0, 0, 0);
		sfqc_host_inst.open();
		tx(OPC_ENTER_4W, 8, 0);
		frame_end();
		chkcfg(0, 0, 0);
	endtask

	task automatic t_enter();
		sfqc_host_inst.open();
		tx(OPC_SET_WRAP, 8, 0);
		tx(8'h60, 8, 1);
		frame_end();
		chkcfg(0, 0, 3);
		@(posedge clk);
		#1 qe = 1'b1;
		repeat (4) @(posedge clk);
		sfqc_host_inst.open();
		tx(OPC_ENTER_4W, 8, 0);
		frame_end();
		chkcfg(1, 0, 3);
	endtask

	// parameters set again after entry, before any read
	task automatic t_parm();
		for (int k = 0; k < 4; k++)
		begin
			sfqc_host_inst.open();
			tx(OPC_SET_PARM, 2, 1);
			tx({2'h0, 2'(k), 2'h0, 2'(k)}, 2, 1);
			frame_end();
			chkcfg(1, 2'(k), 2'(k));
		end
		sfqc_host_inst.open();
		tx(OPC_SET_PARM, 2, 1);
		tx(8'h11, 2, 1);
		frame_end();
		chkcfg(1, 1, 1);
	endtask

	// Start two bytes before the end of a 16 byte window
	task automatic t_burst();
		sfqc_host_inst.open();
		tx(OPC_BURST_WRAP, 2, 1);
		tx(24'h00001e, 6, 1);
		tx(0, 4, 1);
		tx(0, 8, 1);
		frame_end();
		chk("burst_data", {8'h1e, 8'h1f, 8'h10, 8'h11} ^ {4{8'h3c}}, r);
	endtask

	task automatic t_exit();
		sfqc_host_inst.open();
		tx(OPC_EXIT_4W, 2, 1);
		frame_end();
		chkcfg(0, 1, 1);
	endtask

	task automatic t_spi_read();
		sfqc_host_inst.open();
		tx(OPC_FAST_READ, 8, 0);
		tx(24'h000100, 24, 0);
		tx(0, 4, 0);
		tx(0, 16, 0);
		frame_end();
		chk("fast_read", {8'h00, 8'h01} ^ 16'h3c3c, r);
	endtask

	// reset pair restores the defaults from a non-default setting
	task automatic t_reset();
		sfqc_host_inst.open();
		tx(OPC_RST_EN, 8, 0);
		frame_end();
		sfqc_host_inst.open();
		tx(OPC_RST, 8, 0);
		frame_end();
		chkcfg(0, 0, 0);
	endtask

	// no write commands are issued, so no start-up wait applies
	initial
	begin
		rst_n = 1'b0;
		qe = 1'b0;
		sel = 4'h4;
		num_errors = 0;
		checked = 0;
		cyc = 0;
		repeat (2) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (3) @(posedge clk);
		chkcfg(0, 0, 0);
		t_uid();
		t_refuse();
		t_enter();
		t_parm();
		t_burst();
		t_exit();
		t_spi_read();
		t_reset();
		final_report();
	end
endmodule

`default_nettype wire
